/* design/ccpwm_unit.sv */
// Behaviour
// RULE1: software runs the 16-bit timer in timer or synchronized counter mode.
// RULE2: software never clocks that timer straight from the system clock.
// RULE3: software masks the event and clears the flag after a capture mode change.
// RULE4: quarter-rate timer holds its count in sleep; external clock keeps capture alive.
// RULE5: compare pair is checked against the 16-bit timer every cycle.
// RULE6: a match toggles, sets, clears or pulses the pin as the mode says.
// RULE7: a match sets the event flag with the pin action and may trigger conversion.
// RULE8: toggle-with-clear and pulse-with-clear zero the timer after a match.
// RULE9: writing zero to the control register drives the compare latch low.
// RULE10: if the match vanishes before the clear edge, the timer clear is skipped.
// RULE11: compare works in sleep only on a running timer; enabled events wake.
// RULE12: pulse-width mode drives a waveform of up to ten bits resolution.
// RULE13: software clocks the period timer from the quarter-rate clock.
// RULE14: period is (limit + 1) times four system clocks times the prescale ratio.
// RULE15: after count equals limit, clear count, load duty buffer, set pin unless zero.
// RULE16: no postscaler takes part in the pulse-width period.
// RULE17: duty is ten bits in the pair, aligned by format, used after next period.
// RULE18: software routes the pin, loads setup, starts the timer, then drives.
// RULE19: mode field codes disabled, compare, capture and pulse-width operations.
// RULE20: time base is count plus two low bits from clock phase or prescaler.
// RULE21: when the time base equals the buffered duty the pin goes low.
// RULE22: format one means left-aligned duty, zero means right-aligned.
// RULE23: each capture event copies the timer into the pair and sets the flag.
// RULE24: with the enable bit clear nothing captures, compares, modulates or flags; the code still sets the period timer flag on each period rollover.
`timescale 1ns/1ns
`default_nettype none
module ccpwm_unit
  import ccpwm_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic sleep,
  input wire logic capture_pin,
  input wire logic timer_ext_clock_pin,
  output logic unit_pin,
  output logic conv_trigger,
  output logic wake_request
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [7:0] unit_control;
  logic [7:0] match_value_low;
  logic [7:0] match_value_high;
  logic [7:0] timer_count_low;
  logic [7:0] timer_count_high;
  logic [1:0] timer_control;
  logic [7:0] pwm_base_count;
  logic [7:0] pwm_period_limit;
  logic [7:0] period_timer_control;
  logic unit_event_flag;
  logic period_timer_flag;
  logic unit_event_irq_enable;
  logic conv_select;
  logic [7:0] a_addr;
  logic a_act;
  logic a_wr;
  logic [1:0] quarter;
  logic cap_s1, cap_s2, ext_s1, ext_s2, ext_s3;
  logic match_d;
  logic clr_pend;
  logic pulse_d;
  logic [8:0] sub_cnt;
  logic [9:0] duty_buf;
  logic cap_evt;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  wire accept = hsel & htrans[1] & hready;
  wire wr_en = a_act & a_wr;
  wire wr_ctrl = wr_en && a_addr == OFF_UNIT_CONTROL;
  wire wr_mlo = wr_en && a_addr == OFF_MATCH_LOW;
  wire wr_mhi = wr_en && a_addr == OFF_MATCH_HIGH;
  wire wr_tlo = wr_en && a_addr == OFF_TIMER_LOW;
  wire wr_thi = wr_en && a_addr == OFF_TIMER_HIGH;
  wire wr_tctl = wr_en && a_addr == OFF_TIMER_CONTROL;
  wire wr_pcnt = wr_en && a_addr == OFF_PWM_BASE_COUNT;
  wire wr_plim = wr_en && a_addr == OFF_PWM_PERIOD_LIMIT;
  wire wr_pctl = wr_en && a_addr == OFF_PERIOD_TIMER_CONTROL;
  wire wr_stat = wr_en && a_addr == OFF_STATUS;
  wire wr_ectl = wr_en && a_addr == OFF_EVENT_CONTROL;
  wire [7:0] wbyte = hwdata[7:0];
  wire [7:0] status_word = {6'h00, period_timer_flag, unit_event_flag};
  wire [7:0] rd_byte =
    (a_addr == OFF_UNIT_CONTROL) ? unit_control :
    (a_addr == OFF_MATCH_LOW) ? match_value_low :
    (a_addr == OFF_MATCH_HIGH) ? match_value_high :
    (a_addr == OFF_TIMER_LOW) ? timer_count_low :
    (a_addr == OFF_TIMER_HIGH) ? timer_count_high :
    (a_addr == OFF_TIMER_CONTROL) ? {6'h00, timer_control} :
    (a_addr == OFF_PWM_BASE_COUNT) ? pwm_base_count :
    (a_addr == OFF_PWM_PERIOD_LIMIT) ? pwm_period_limit :
    (a_addr == OFF_PERIOD_TIMER_CONTROL) ? period_timer_control :
    (a_addr == OFF_STATUS) ? status_word :
    (a_addr == OFF_EVENT_CONTROL) ? {6'h00, conv_select, unit_event_irq_enable} : 8'h00;

  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  wire [3:0] mode = unit_control[3:0];
  wire en = unit_control[UC_EN_BIT];
  wire fmt = unit_control[UC_FMT_BIT];
  wire cmp_on = en & ccpwm_is_compare(mode); // see RULE24
  wire pwm_on = en & ccpwm_is_pwm(mode); // see RULE19
  wire cap_on = en & ccpwm_is_capture(mode);
  wire clr_mode = (mode == CCPWM_TGL_CLR) || (mode == CCPWM_PULSE_CLR); // see RULE8

  // ----------------------------------------
  // 16-bit timer and compare
  // ----------------------------------------
  // quarter-rate tick stalls in sleep; an external clock keeps counting there
  wire q_tick = !sleep && quarter == QUARTER_LAST; // see RULE4
  wire ext_rise = ext_s2 & ~ext_s3;
  wire t_tick = timer_control[TC_ON_BIT] & (timer_control[TC_EXT_BIT] ? ext_rise : q_tick);
  wire [15:0] timer16 = {timer_count_high, timer_count_low};
  wire [15:0] match16 = {match_value_high, match_value_low};
  wire match = timer16 == match16; // see RULE5
  wire cmp_evt = cmp_on & match & ~match_d; // see RULE11
  // clear fires one edge after the event, and only if the match still holds
  wire t_clear = clr_pend & match; // see RULE10
  wire [15:0] t_inc = timer16 + 16'h0001;
  wire [15:0] next_timer = t_clear ? 16'h0000 : (t_tick ? t_inc : timer16);

  // ----------------------------------------
  // pulse-width time base
  // ----------------------------------------
  wire [2:0] ps = period_timer_control[PTC_PS_LSB +: 3];
  wire p_run = period_timer_control[PTC_ON_BIT] & ~sleep;
  wire [8:0] sub_last = (SYS_PER_TICK << ps) - 9'h001; // see RULE14
  wire sub_wrap = sub_cnt == sub_last;
  wire p_roll = p_run & sub_wrap & (pwm_base_count == pwm_period_limit); // see RULE16
  // the pin is a flop, so it looks one step ahead and falls just as the time base reaches the duty
  wire [8:0] sub_step = sub_wrap ? 9'h000 : sub_cnt + 9'h001;
  wire [7:0] base_step = sub_wrap ? pwm_base_count + 8'h01 : pwm_base_count;
  wire [8:0] sub_shift = sub_step >> ps;
  wire [9:0] next_time_base = {base_step, sub_shift[1:0]}; // see RULE20
  wire [9:0] duty_val = fmt ? {match_value_high, match_value_low[7:6]} :
                              {match_value_high[1:0], match_value_low}; // see RULE22
  wire [9:0] next_duty_buf = p_roll ? duty_val : duty_buf; // see RULE17

  // ----------------------------------------
  // pin and event sources
  // ----------------------------------------
  wire ev_set = cap_evt | cmp_evt | (pwm_on & p_roll);
  logic next_pin;
  always_comb begin
    next_pin = unit_pin;
    if (pwm_on) begin
      if (p_roll) begin
        next_pin = duty_val != 10'h000; // see RULE15
      end else if (p_run && next_time_base == duty_buf) begin
        next_pin = 1'b0; // see RULE21
      end
    end else if (wr_ctrl && wbyte == 8'h00) begin
      next_pin = 1'b0; // see RULE9
    end else if (!en || mode == CCPWM_OFF) begin
      next_pin = 1'b0;
    end else if (cmp_evt) begin
      case (mode)
        CCPWM_TGL_CLR, CCPWM_TGL: next_pin = ~unit_pin; // see RULE6
        CCPWM_SET, CCPWM_PULSE, CCPWM_PULSE_CLR: next_pin = 1'b1;
        CCPWM_CLR: next_pin = 1'b0;
        default: next_pin = unit_pin;
      endcase
    end else if (pulse_d) begin
      next_pin = 1'b0;
    end
  end

  // ----------------------------------------
  // capture edge detector
  // ----------------------------------------
  ccpwm_capture_detect u_capture (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .arm(cap_on),
    .mode(mode),
    .sig(cap_s2),
    .event_pulse(cap_evt)
  );

  // pin synchronisers; capture uses the second stage, the external clock edge uses the second and third
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {cap_s1, cap_s2, ext_s1, ext_s2, ext_s3} <= 5'h00;
    end else if (ce) begin
      {cap_s1, cap_s2} <= {capture_pin, cap_s1};
      {ext_s1, ext_s2, ext_s3} <= {timer_ext_clock_pin, ext_s1, ext_s2};
    end
  end

  // bus slave: writes are zero-wait, reads stall one cycle to see fresh data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_act <= 1'b0;
      a_wr <= 1'b0;
      a_addr <= 8'h00;
      hreadyout <= 1'b1;
      hrdata <= 32'h0000_0000;
      hresp <= 1'b0;
    end else if (ce) begin
      hresp <= 1'b0;
      if (a_act && !a_wr && !hreadyout) begin
        hrdata <= {24'h000000, rd_byte};
        hreadyout <= 1'b1;
        a_act <= 1'b0;
      end else begin
        a_act <= accept;
        a_wr <= hwrite;
        a_addr <= haddr[7:0] & 8'hfc;
        hreadyout <= !(accept && !hwrite);
      end
    end
  end

  // software registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      unit_control <= RST_UNIT_CONTROL;
      timer_control <= 2'h0;
      pwm_period_limit <= RST_PWM_PERIOD_LIMIT;
      period_timer_control <= 8'h00;
      unit_event_irq_enable <= 1'b0;
      conv_select <= 1'b0;
    end else if (ce) begin
      if (wr_ctrl) unit_control <= wbyte & 8'hdf;
      if (wr_tctl) timer_control <= wbyte[1:0];
      if (wr_plim) pwm_period_limit <= wbyte;
      if (wr_pctl) period_timer_control <= wbyte & 8'hf0;
      if (wr_ectl) {conv_select, unit_event_irq_enable} <= wbyte[1:0];
    end
  end

  // capture pair, 16-bit timer and compare sequencing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {match_value_high, match_value_low} <= 16'h0000;
      {timer_count_high, timer_count_low} <= 16'h0000;
      quarter <= 2'h0;
      match_d <= 1'b0;
      clr_pend <= 1'b0;
      pulse_d <= 1'b0;
    end else if (ce) begin
      if (!sleep) quarter <= quarter + 2'h1;
      if (cap_evt) begin
        {match_value_high, match_value_low} <= timer16; // see RULE23
      end else begin
        if (wr_mlo) match_value_low <= wbyte;
        if (wr_mhi) match_value_high <= wbyte;
      end
      timer_count_low <= wr_tlo ? wbyte : next_timer[7:0]; // see RULE8
      timer_count_high <= wr_thi ? wbyte : next_timer[15:8];
      match_d <= match & cmp_on;
      clr_pend <= cmp_evt & clr_mode;
      pulse_d <= cmp_evt && (mode == CCPWM_PULSE || mode == CCPWM_PULSE_CLR);
    end
  end

  // period timer and duty buffer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sub_cnt <= 9'h000;
      pwm_base_count <= 8'h00;
      duty_buf <= 10'h000;
    end else if (ce) begin
      duty_buf <= next_duty_buf;
      if (p_run) sub_cnt <= sub_wrap ? 9'h000 : sub_cnt + 9'h001;
      if (wr_pcnt) begin
        pwm_base_count <= wbyte;
      end else if (p_roll) begin
        pwm_base_count <= 8'h00; // see RULE15
      end else if (p_run && sub_wrap) begin
        pwm_base_count <= pwm_base_count + 8'h01;
      end
    end
  end

  // flags and outputs; a hardware set beats a same-cycle write-one clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      unit_event_flag <= 1'b0;
      period_timer_flag <= 1'b0;
      unit_pin <= 1'b0;
      conv_trigger <= 1'b0;
      wake_request <= 1'b0;
    end else if (ce) begin
      unit_event_flag <= ev_set | (unit_event_flag & ~(wr_stat & wbyte[ST_EVENT_BIT])); // see RULE7
      period_timer_flag <= p_roll | (period_timer_flag & ~(wr_stat & wbyte[ST_PERIOD_BIT]));
      unit_pin <= next_pin; // see RULE12
      conv_trigger <= cmp_evt & conv_select; // see RULE7
      wake_request <= (unit_event_flag | ev_set) & unit_event_irq_enable; // see RULE11
    end
  end
endmodule : ccpwm_unit
`default_nettype wire

/* design/ccpwm_pkg.sv */
package ccpwm_pkg;
  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_UNIT_CONTROL = 8'h00;
  localparam logic [7:0] OFF_MATCH_LOW = 8'h04;
  localparam logic [7:0] OFF_MATCH_HIGH = 8'h08;
  localparam logic [7:0] OFF_TIMER_LOW = 8'h0c;
  localparam logic [7:0] OFF_TIMER_HIGH = 8'h10;
  localparam logic [7:0] OFF_TIMER_CONTROL = 8'h14;
  localparam logic [7:0] OFF_PWM_BASE_COUNT = 8'h18;
  localparam logic [7:0] OFF_PWM_PERIOD_LIMIT = 8'h1c;
  localparam logic [7:0] OFF_PERIOD_TIMER_CONTROL = 8'h20;
  localparam logic [7:0] OFF_STATUS = 8'h24;
  localparam logic [7:0] OFF_EVENT_CONTROL = 8'h28;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int UC_EN_BIT = 7;
  localparam int UC_OUT_BIT = 5;
  localparam int UC_FMT_BIT = 4;
  localparam int TC_ON_BIT = 0;
  localparam int TC_EXT_BIT = 1;
  localparam int PTC_ON_BIT = 7;
  localparam int PTC_PS_LSB = 4;
  localparam int ST_EVENT_BIT = 0;
  localparam int ST_PERIOD_BIT = 1;
  localparam int EC_IRQ_EN_BIT = 0;
  localparam int EC_CONV_SEL_BIT = 1;
  // ----------------------------------------
  // reset values and counts
  // ----------------------------------------
  localparam logic [7:0] RST_UNIT_CONTROL = 8'h00;
  localparam logic [7:0] RST_PWM_PERIOD_LIMIT = 8'hff;
  localparam logic [1:0] QUARTER_LAST = 2'h3;
  localparam logic [8:0] SYS_PER_TICK = 9'h004;
  // ----------------------------------------
  // mode field encodings
  // ----------------------------------------
  typedef enum logic [3:0] {
    CCPWM_OFF = 4'h0, CCPWM_TGL_CLR = 4'h1, CCPWM_TGL = 4'h2, CCPWM_CAP_ANY = 4'h3,
    CCPWM_CAP_FALL = 4'h4, CCPWM_CAP_RISE = 4'h5, CCPWM_CAP_R4 = 4'h6, CCPWM_CAP_R16 = 4'h7,
    CCPWM_SET = 4'h8, CCPWM_CLR = 4'h9, CCPWM_PULSE = 4'ha, CCPWM_PULSE_CLR = 4'hb
  } ccpwm_mode_e;

  // capture modes sit between every-edge and every-16th
  function automatic logic ccpwm_is_capture(input logic [3:0] m);
    return (m >= CCPWM_CAP_ANY) && (m <= CCPWM_CAP_R16);
  endfunction : ccpwm_is_capture

  // pulse-width takes the whole top quarter of the code space
  function automatic logic ccpwm_is_pwm(input logic [3:0] m);
    return m[3:2] == 2'h3;
  endfunction : ccpwm_is_pwm

  function automatic logic ccpwm_is_compare(input logic [3:0] m);
    return (m != CCPWM_OFF) && !ccpwm_is_capture(m) && !ccpwm_is_pwm(m);
  endfunction : ccpwm_is_compare
endpackage : ccpwm_pkg

/* design/ccpwm_capture_detect.sv */
`timescale 1ns/1ns
`default_nettype none
module ccpwm_capture_detect
  import ccpwm_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic arm,
  input wire logic [3:0] mode,
  input wire logic sig,
  output logic event_pulse
);
  logic sig_d;
  logic [3:0] mode_d;
  logic [3:0] edge_cnt;
  logic rise;
  logic fall;
  logic hit;
  logic [3:0] cnt_last;

  // ----------------------------------------
  // edge decode
  // ----------------------------------------
  assign rise = sig & ~sig_d;
  assign fall = ~sig & sig_d;
  assign cnt_last = (mode == CCPWM_CAP_R16) ? 4'hf : 4'h3;
  assign hit = (mode == CCPWM_CAP_ANY) ? (rise | fall) :
               (mode == CCPWM_CAP_FALL) ? fall :
               (mode == CCPWM_CAP_RISE) ? rise :
               (rise && edge_cnt == cnt_last);

  // prescale count restarts on any mode change, so a new ratio starts clean
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sig_d <= 1'b0;
      mode_d <= 4'h0;
      edge_cnt <= 4'h0;
      event_pulse <= 1'b0;
    end else if (ce) begin
      sig_d <= sig;
      mode_d <= mode;
      event_pulse <= arm & hit; // see RULE23
      if (!arm || mode != mode_d) begin
        edge_cnt <= 4'h0;
      end else if (rise) begin
        edge_cnt <= (edge_cnt == cnt_last) ? 4'h0 : edge_cnt + 4'h1;
      end
    end
  end
endmodule : ccpwm_capture_detect
`default_nettype wire

/* tb/ccpwm_unit_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
module ccpwm_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic unit_pin,
  input wire logic conv_trigger
);
  // ----------------------------------------
  // bus and pin relations
  // ----------------------------------------
  // a request only counts when the clock enable lets the slave move
  wire logic take = hsel && htrans[1] && hready && ce;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_resp_okay: assert property (hresp == 1'b0) else $error("slave answered with an error");
  a_rdata_upper: assert property (hrdata[31:8] == 24'h0) else $error("read data upper bits not zero");
  a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read did not take exactly one wait cycle");
  a_write_nowait: assert property (take && hwrite |=> hreadyout) else $error("write stalled the bus");
  a_wait_cause: assert property ($fell(hreadyout) |-> $past(take && !hwrite))
    else $error("wait state without a read");
  // read data must not wander between reads, software may sample it late
  a_rdata_hold: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
    else $error("read data changed outside a read");
  a_trig_pulse: assert property (conv_trigger && ce |=> !conv_trigger)
    else $error("conversion trigger longer than one cycle");
  a_ce_freeze: assert property (!ce |=> $stable(unit_pin) && $stable(conv_trigger) && $stable(hreadyout))
    else $error("outputs moved while clock enable low");
endmodule : ccpwm_chk

bind ccpwm_unit ccpwm_chk u_chk (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .unit_pin(unit_pin), .conv_trigger(conv_trigger));
`default_nettype wire

/* tb/ccpwm_pin_model.sv */
`timescale 1ns/1ns
`default_nettype none
module ccpwm_pin_model (
  input wire logic hclk,
  input wire logic unit_pin,
  output logic capture_pin,
  output logic timer_ext_clock_pin
);
  initial begin
    capture_pin = 1'b0;
    timer_ext_clock_pin = 1'b0;
  end
  // ----------------------------------------
  // event source and external timer clock
  // ----------------------------------------
  // halves stay well over the two-flop sync so no edge is lost; both lines idle low
  task automatic pulses(input int n, input int ext);
    for (int i = 0; i < 2 * n; i++) begin
      repeat (ext ? 4 : 8) @(posedge hclk);
      if (ext) timer_ext_clock_pin <= !timer_ext_clock_pin;
      else capture_pin <= !capture_pin;
    end
  endtask : pulses
  // load side: high time and whole period of the waveform, in hclk cycles
  task automatic measure(output int hi, output int tot);
    int n;
    n = 0;
    hi = 0;
    while (unit_pin !== 1'b0 && n < 2000) begin @(posedge hclk); n++; end
    while (unit_pin !== 1'b1 && n < 2000) begin @(posedge hclk); n++; end
    while (unit_pin === 1'b1 && hi < 2000) begin @(posedge hclk); hi++; end
    tot = hi;
    while (unit_pin === 1'b0 && tot < 2000) begin @(posedge hclk); tot++; end
  endtask : measure
endmodule : ccpwm_pin_model
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import ccpwm_pkg::*;
  logic hclk, hresetn, ce, hsel, hwrite, sleep, cap, extc, pe;
  logic [31:0] haddr, hwdata, hrdata, q, lfsr;
  logic [1:0] htrans;
  logic hreadyout, hresp, unit_pin, conv_trigger, wake_request;
  int fail_count, compares, n, hi, tot;
  logic [31:0] shadow [logic [7:0]];
  logic [3:0] cm [6] = '{CCPWM_TGL_CLR, CCPWM_TGL, CCPWM_SET, CCPWM_CLR, CCPWM_PULSE, CCPWM_PULSE_CLR};
  int cap_m [5] = '{3, 4, 5, 6, 7};
  int cap_k [5] = '{1, 1, 1, 4, 16};
  // prescale, format, high byte, low byte, duty
  int pw [5][5] = '{'{0, 0, 0, 6, 6}, '{1, 0, 0, 6, 6}, '{0, 1, 1, 128, 6}, '{2, 0, 0, 13, 13}, '{0, 0, 0, 0, 0}};

  ccpwm_unit dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .sleep(sleep), .capture_pin(cap), .timer_ext_clock_pin(extc),
    .unit_pin(unit_pin), .conv_trigger(conv_trigger), .wake_request(wake_request));
  ccpwm_pin_model pins (.hclk(hclk), .unit_pin(unit_pin), .capture_pin(cap), .timer_ext_clock_pin(extc));

  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_sim;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  // no fixed latency: wait for hready sampled high; only the watchdog ends a stuck wait
  task automatic rdy;
    do begin @(posedge hclk); end while (hreadyout !== 1'b1);
  endtask : rdy
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    rdy();
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    q = hrdata;
    if (w) shadow[a] = d & 32'hff;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0);
    chk(q, e);
  endtask : rc
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  // hang guard, far beyond the expected run length
  initial begin
    #(40 * 100000);
    fail_count++;
    end_sim();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    hresetn = 1'b0;
    ce = 1'b1;
    hsel = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    sleep = 1'b0;
    lfsr = 32'h4f27;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    // reset values, including one unmapped word
    for (int a = 0; a <= 8'h2c; a += 4) rc(8'(a), (a == OFF_PWM_PERIOD_LIMIT) ? 32'hff : 32'h0);
    for (int i = 0; i < 4; i++) begin
      lfsr = nxt(lfsr);
      wr(OFF_MATCH_LOW, lfsr);
      wr(OFF_PWM_PERIOD_LIMIT, lfsr >> 8);
      wr(8'h2c, lfsr);
      rc(OFF_MATCH_LOW, shadow[OFF_MATCH_LOW]);
      rc(OFF_PWM_PERIOD_LIMIT, shadow[OFF_PWM_PERIOD_LIMIT]);
      rc(8'h2c, 32'h0);
    end
    // every compare action, starting from a cleared latch
    foreach (cm[i]) begin
      wr(OFF_UNIT_CONTROL, 32'h0);
      repeat (2) @(posedge hclk);
      chk(32'(unit_pin), 32'h0);
      wr(OFF_TIMER_CONTROL, 32'h0);
      wr(OFF_TIMER_LOW, 32'h0);
      wr(OFF_TIMER_HIGH, 32'h0);
      wr(OFF_MATCH_LOW, 32'h10);
      wr(OFF_MATCH_HIGH, 32'h0);
      wr(OFF_STATUS, 32'h3);
      wr(OFF_EVENT_CONTROL, 32'h3);
      wr(OFF_UNIT_CONTROL, 8'h80 | cm[i]);
      wr(OFF_TIMER_CONTROL, 32'h1);
      n = 0;
      do begin @(posedge hclk); n++; end while (conv_trigger !== 1'b1 && n < 600);
      chk(32'(n < 600), 32'h1);
      pe = (cm[i] != CCPWM_CLR);
      chk(32'(unit_pin), 32'(pe));
      chk(32'(wake_request), 32'h1);
      @(posedge hclk);
      chk(32'(conv_trigger), 32'h0);
      chk(32'(unit_pin), 32'(pe && cm[i] < CCPWM_PULSE));
      rc(OFF_STATUS, 32'h1);
      xfer(OFF_TIMER_LOW, 1'b0, 32'h0);
      chk(32'(q < 32'h10), 32'(cm[i] == CCPWM_TGL_CLR || cm[i] == CCPWM_PULSE_CLR));
    end
    // module disabled: a match passes unseen
    wr(OFF_UNIT_CONTROL, 32'h0);
    wr(OFF_TIMER_CONTROL, 32'h0);
    wr(OFF_TIMER_LOW, 32'h0);
    wr(OFF_STATUS, 32'h3);
    wr(OFF_UNIT_CONTROL, CCPWM_SET);
    wr(OFF_TIMER_CONTROL, 32'h1);
    repeat (120) @(posedge hclk);
    chk(32'(unit_pin), 32'h0);
    rc(OFF_STATUS, 32'h0);
    // capture edges and prescaled counts on a stopped timer
    wr(OFF_TIMER_CONTROL, 32'h0);
    wr(OFF_TIMER_LOW, 32'h3c);
    wr(OFF_TIMER_HIGH, 32'h12);
    foreach (cap_m[i]) begin
      wr(OFF_EVENT_CONTROL, 32'h0);
      wr(OFF_UNIT_CONTROL, 8'h80 | 8'(cap_m[i]));
      wr(OFF_MATCH_LOW, 32'h0);
      wr(OFF_MATCH_HIGH, 32'h0);
      wr(OFF_STATUS, 32'h1);
      if (cap_k[i] > 1) pins.pulses(cap_k[i] - 1, 0);
      rc(OFF_STATUS, 32'h0);
      pins.pulses(1, 0);
      repeat (6) @(posedge hclk);
      rc(OFF_STATUS, 32'h1);
      rc(OFF_MATCH_LOW, 32'h3c);
      rc(OFF_MATCH_HIGH, 32'h12);
    end
    // sleep holds the quarter-rate count, an external clock keeps counting
    wr(OFF_UNIT_CONTROL, 32'h0);
    wr(OFF_TIMER_LOW, 32'h0);
    wr(OFF_TIMER_CONTROL, 32'h1);
    repeat (20) @(posedge hclk);
    sleep <= 1'b1;
    xfer(OFF_TIMER_LOW, 1'b0, 32'h0);
    hi = q;
    repeat (3) @(posedge hclk);
    ce <= 1'b0;
    repeat (5) @(posedge hclk);
    ce <= 1'b1;
    repeat (30) @(posedge hclk);
    rc(OFF_TIMER_LOW, 32'(hi));
    wr(OFF_TIMER_CONTROL, 32'h3);
    wr(OFF_TIMER_LOW, 32'h0);
    pins.pulses(5, 1);
    repeat (6) @(posedge hclk);
    rc(OFF_TIMER_LOW, 32'h5);
    sleep <= 1'b0;
    wr(OFF_TIMER_CONTROL, 32'h0);
    // pulse-width: limit 3 gives a period of sixteen system clocks times the prescale ratio
    wr(OFF_PWM_PERIOD_LIMIT, 32'h3);
    foreach (pw[i]) begin
      wr(OFF_UNIT_CONTROL, 8'h8c | 8'(i % 4) | 8'(pw[i][1] << 4));
      wr(OFF_MATCH_LOW, 32'(pw[i][3]));
      wr(OFF_MATCH_HIGH, 32'(pw[i][2]));
      wr(OFF_STATUS, 32'h3);
      wr(OFF_PERIOD_TIMER_CONTROL, 8'h80 | 8'(pw[i][0] << 4));
      // the first period may still carry the old buffered duty
      pins.measure(hi, tot);
      pins.measure(hi, tot);
      chk(32'(hi), 32'(pw[i][4] << pw[i][0]));
      if (pw[i][4] != 0) chk(32'(tot), 32'(16 << pw[i][0]));
      rc(OFF_STATUS, 32'h3);
    end
    end_sim();
  end
endmodule : testbench
`default_nettype wire
